/* core/dual_dac_pkg.sv */
/*
 package for the two-channel converter control block: special function register
 addresses, reset values, control bit positions and the struct that carries the
 per-channel analog controls.
 assumes an 8-bit special function register bus from the processor core.
*/
package dual_dac_pkg;
   localparam int CODE_W = 12;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 8;

   // register addresses
   localparam logic [ADDR_W-1:0] CHAN0_CODE_LOW_ADDR = 8'hF9;
   localparam logic [ADDR_W-1:0] CHAN0_CODE_HIGH_ADDR = 8'hFA;
   localparam logic [ADDR_W-1:0] CHAN1_CODE_LOW_ADDR = 8'hFB;
   localparam logic [ADDR_W-1:0] CHAN1_CODE_HIGH_ADDR = 8'hFC;
   localparam logic [ADDR_W-1:0] CONVERTER_CONTROL_ADDR = 8'hFD;

   // values after reset
   localparam logic [BYTE_W-1:0] CONVERTER_CONTROL_RESET = 8'h04;
   localparam logic [BYTE_W-1:0] CODE_BYTE_RESET = 8'h00;

   // converter_control bit positions
   localparam int MODE_8BIT_BIT = 7;
   localparam int CHAN1_RANGE_BIT = 6;
   localparam int CHAN0_RANGE_BIT = 5;
   localparam int CHAN1_ZERO_N_BIT = 4;
   localparam int CHAN0_ZERO_N_BIT = 3;
   localparam int ASYNC_UPDATE_BIT = 2;
   localparam int CHAN1_POWER_BIT = 1;
   localparam int CHAN0_POWER_BIT = 0;

   // controls of one channel toward its analog core
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic range_supply;
      logic zero_force_n;
      logic power_on;
   } chan_ctrl_s;
endpackage

/* core/dual_dac_register_control.sv */
/*
 register side of two 12-bit voltage-output converters: control register, code
 byte pairs, update timing and the controls driven to the analog cores.
 assumes the processor core presents one-cycle write strobes and a read address
 on the core clock; read data is registered and valid the cycle after the read.
*/
// Overview of operation
// [R1] two independent channels, each a 12-bit code in a high and low byte
// [R2] in 12-bit mode the output code refreshes on the low-byte write
// [R3] software writes high byte before low byte of a channel
// [R4] control bit 7 picks 8-bit mode (low byte only) or 12-bit mode
// [R5] control bit 6 selects channel 1 supply range (1) or reference range (0)
// [R6] control bit 5 selects channel 0 supply range (1) or reference range (0)
// [R7] control bit 4 low forces channel 1 output to zero volts
// [R8] control bit 3 low forces channel 0 output to zero volts
// [R9] control bit 2 high: a channel updates when its low byte is written
// [R10] control bit 2 low: writes held; both channels update when bit set
// [R11] control bit 1 powers channel 1 up (1) or down (0)
// [R12] control bit 0 powers channel 0 up (1) or down (0)
// [R13] software right-justifies the code: low eight bits low, top four high
// [R14] channel outputs share pins with analog inputs four and five
// [R15] software keeps the analog-to-digital converter on for reference range
// [R16] after power-on both channels are off with outputs in high impedance
// [R17] registers read back as written; high byte upper nibble is ignored
// [R18] in 8-bit mode the low byte drives the top eight code bits
module dual_dac_register_control
   import dual_dac_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // special function register bus
   input wire logic [ADDR_W-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [BYTE_W-1:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [BYTE_W-1:0] sfr_rdata_q,
   output logic sfr_hit_q,
   // analog core controls
   output chan_ctrl_s chan0_ctrl_q,
   output chan_ctrl_s chan1_ctrl_q,
   // pin sharing toward the analog input multiplexer
   output logic analog_input_four_taken_q,
   output logic analog_input_five_taken_q
);

   logic [BYTE_W-1:0] converter_control_q;
   logic [BYTE_W-1:0] chan0_code_low_q;
   logic [BYTE_W-1:0] chan0_code_high_q;
   logic [BYTE_W-1:0] chan1_code_low_q;
   logic [BYTE_W-1:0] chan1_code_high_q;
   logic wr_ctrl;
   logic wr_c0_low;
   logic wr_c0_high;
   logic wr_c1_low;
   logic wr_c1_high;
   logic mode_8bit;
   logic async_update;
   logic sync_rise;
   logic load0;
   logic load1;
   logic [BYTE_W-1:0] ctrl_d;

   // active code from one byte pair at the selected resolution
   function automatic logic [CODE_W-1:0] form_code(input logic [BYTE_W-1:0] low,
                                                   input logic [BYTE_W-1:0] high,
                                                   input logic eight_bit);
      if (eight_bit) begin
         form_code = {low, 4'h0}; // see [R18] [R4]
      end else begin
         form_code = {high[3:0], low}; // see [R17] [R13]
      end
   endfunction

   assign wr_ctrl = sfr_wr && (sfr_addr == CONVERTER_CONTROL_ADDR);
   assign wr_c0_low = sfr_wr && (sfr_addr == CHAN0_CODE_LOW_ADDR);
   assign wr_c0_high = sfr_wr && (sfr_addr == CHAN0_CODE_HIGH_ADDR);
   assign wr_c1_low = sfr_wr && (sfr_addr == CHAN1_CODE_LOW_ADDR);
   assign wr_c1_high = sfr_wr && (sfr_addr == CHAN1_CODE_HIGH_ADDR);

   // the control value in force this cycle, including a write landing now
   assign ctrl_d = wr_ctrl ? sfr_wdata : converter_control_q;
   assign mode_8bit = ctrl_d[MODE_8BIT_BIT];
   assign async_update = converter_control_q[ASYNC_UPDATE_BIT];

   // a 0 -> 1 write of the update bit releases both held codes at once
   assign sync_rise = wr_ctrl && sfr_wdata[ASYNC_UPDATE_BIT]
                      && !converter_control_q[ASYNC_UPDATE_BIT]; // see [R10]
   assign load0 = (async_update && wr_c0_low) || sync_rise; // see [R2] [R9]
   assign load1 = (async_update && wr_c1_low) || sync_rise; // see [R2] [R9]

   // control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         converter_control_q <= CONVERTER_CONTROL_RESET;
      end else if (wr_ctrl) begin
         converter_control_q <= sfr_wdata;
      end
   end

   // code byte registers hold whatever software writes; read back unchanged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chan0_code_low_q <= CODE_BYTE_RESET;
         chan0_code_high_q <= CODE_BYTE_RESET;
         chan1_code_low_q <= CODE_BYTE_RESET;
         chan1_code_high_q <= CODE_BYTE_RESET;
      end else begin
         if (wr_c0_low) begin
            chan0_code_low_q <= sfr_wdata; // see [R1]
         end
         if (wr_c0_high) begin
            chan0_code_high_q <= sfr_wdata; // see [R1]
         end
         if (wr_c1_low) begin
            chan1_code_low_q <= sfr_wdata; // see [R1]
         end
         if (wr_c1_high) begin
            chan1_code_high_q <= sfr_wdata; // see [R1]
         end
      end
   end

   // applied codes: the low byte written this cycle is used directly so the
   // output moves one cycle after the write, not two
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chan0_ctrl_q.code <= '0;
         chan1_ctrl_q.code <= '0;
      end else begin
         if (load0) begin
            chan0_ctrl_q.code <= form_code(wr_c0_low ? sfr_wdata : chan0_code_low_q,
                                           chan0_code_high_q, mode_8bit);
         end
         if (load1) begin
            chan1_ctrl_q.code <= form_code(wr_c1_low ? sfr_wdata : chan1_code_low_q,
                                           chan1_code_high_q, mode_8bit);
         end
      end
   end

   // range, clear and power load from the control value in force, on the same edge as the control register;
   // power off after reset leaves the analog outputs in high impedance
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chan0_ctrl_q.range_supply <= 1'b0;
         chan1_ctrl_q.range_supply <= 1'b0;
         chan0_ctrl_q.zero_force_n <= 1'b0;
         chan1_ctrl_q.zero_force_n <= 1'b0;
         chan0_ctrl_q.power_on <= 1'b0; // see [R16]
         chan1_ctrl_q.power_on <= 1'b0; // see [R16]
         analog_input_four_taken_q <= 1'b0;
         analog_input_five_taken_q <= 1'b0;
      end else begin
         chan1_ctrl_q.range_supply <= ctrl_d[CHAN1_RANGE_BIT]; // see [R5]
         chan0_ctrl_q.range_supply <= ctrl_d[CHAN0_RANGE_BIT]; // see [R6]
         chan1_ctrl_q.zero_force_n <= ctrl_d[CHAN1_ZERO_N_BIT]; // see [R7]
         chan0_ctrl_q.zero_force_n <= ctrl_d[CHAN0_ZERO_N_BIT]; // see [R8]
         chan1_ctrl_q.power_on <= ctrl_d[CHAN1_POWER_BIT]; // see [R11]
         chan0_ctrl_q.power_on <= ctrl_d[CHAN0_POWER_BIT]; // see [R12]
         analog_input_four_taken_q <= ctrl_d[CHAN0_POWER_BIT]; // see [R14]
         analog_input_five_taken_q <= ctrl_d[CHAN1_POWER_BIT]; // see [R14]
      end
   end

   // read port; other addresses belong to other peripherals, so no hit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata_q <= 8'h00;
         sfr_hit_q <= 1'b0;
      end else begin
         sfr_hit_q <= 1'b0;
         sfr_rdata_q <= 8'h00;
         if (sfr_rd) begin
            sfr_hit_q <= 1'b1;
            unique case (sfr_addr)
               CONVERTER_CONTROL_ADDR: sfr_rdata_q <= converter_control_q; // see [R17]
               CHAN0_CODE_LOW_ADDR: sfr_rdata_q <= chan0_code_low_q; // see [R17]
               CHAN0_CODE_HIGH_ADDR: sfr_rdata_q <= chan0_code_high_q; // see [R17]
               CHAN1_CODE_LOW_ADDR: sfr_rdata_q <= chan1_code_low_q; // see [R17]
               CHAN1_CODE_HIGH_ADDR: sfr_rdata_q <= chan1_code_high_q; // see [R17]
               default: sfr_hit_q <= 1'b0;
            endcase
         end
      end
   end

endmodule // dual_dac_register_control

/* verification/core_model.sv */
/* processor core model: one-cycle write and read strobes on the register bus.
 assumes the block's clock; requests move 1 ns after a rising edge. */
module core_model
   import dual_dac_pkg::*;
(
   input wire logic clk,
   // requests
   output logic [ADDR_W-1:0] sfr_addr,
   output logic sfr_wr,
   output logic [BYTE_W-1:0] sfr_wdata,
   output logic sfr_rd,
   // answers
   input wire logic [BYTE_W-1:0] sfr_rdata_q,
   input wire logic sfr_hit_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // reference range relies on the converter being powered; no converter is modelled
   initial {sfr_addr, sfr_wr, sfr_wdata, sfr_rd} = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk) #1;
      sfr_wr = 1'b0;
      sfr_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [8:0] r);
      @(posedge clk) #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk) #1;
      sfr_rd = 1'b0;
      r = {sfr_hit_q, sfr_rdata_q};
   endtask
   // high byte first and right-justified, so the low write loads a whole code
   task automatic code(input logic [7:0] lo, input logic [11:0] v);
      wr(lo + 8'h01, {4'h0, v[11:8]});
      wr(lo, v[7:0]);
   endtask
endmodule // core_model

/* verification/dual_dac_checker.sv */
/* checker: analog controls against the last control byte, and read answers.
 assumes it is bound to the top module and writes are spaced by idle cycles. */
module dual_dac_checker
   import dual_dac_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic [ADDR_W-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [BYTE_W-1:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [BYTE_W-1:0] sfr_rdata_q,
   input wire logic sfr_hit_q,
   // analog controls
   input wire chan_ctrl_s chan0_ctrl_q,
   input wire chan_ctrl_s chan1_ctrl_q,
   input wire logic analog_input_four_taken_q
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cw_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk or posedge rst)
      if (rst) cw_q <= CONVERTER_CONTROL_RESET;
      else if (sfr_wr && sfr_addr == CONVERTER_CONTROL_ADDR) cw_q <= sfr_wdata;
   // outputs lag a write by one edge, so judge them after three quiet cycles
   a_range_sel: assert property (!sfr_wr [*3] |->
      {chan1_ctrl_q.range_supply, chan0_ctrl_q.range_supply} == cw_q[6:5]) else $error("range");
   a_zero_force: assert property (!sfr_wr [*3] |->
      {chan1_ctrl_q.zero_force_n, chan0_ctrl_q.zero_force_n} == cw_q[4:3]) else $error("zero");
   a_power_bits: assert property (!sfr_wr [*3] |->
      {chan1_ctrl_q.power_on, chan0_ctrl_q.power_on} == cw_q[1:0]) else $error("power");
   a_pin_share: assert property (!sfr_wr [*3] |-> analog_input_four_taken_q == cw_q[0])
      else $error("pin share");
   a_async_load: assert property (sfr_wr && sfr_addr == CHAN0_CODE_LOW_ADDR && cw_q[2]
      && !cw_q[7] |=> ##1 chan0_ctrl_q.code[7:0] == $past(sfr_wdata, 2)) else $error("load");
   a_sync_hold: assert property (!cw_q[2] && !$past(cw_q[2]) && !(sfr_wr
      && sfr_addr == CONVERTER_CONTROL_ADDR) |=> $stable(chan0_ctrl_q.code)) else $error("held");
   a_read_hit: assert property (sfr_rd && sfr_addr >= CHAN0_CODE_LOW_ADDR
      && sfr_addr <= CONVERTER_CONTROL_ADDR |=> sfr_hit_q) else $error("hit");
   a_read_quiet: assert property (!sfr_rd |=> sfr_rdata_q == '0 && !sfr_hit_q)
      else $error("quiet");
endmodule // dual_dac_checker
bind dual_dac_register_control dual_dac_checker chk (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
   .sfr_hit_q(sfr_hit_q), .chan0_ctrl_q(chan0_ctrl_q), .chan1_ctrl_q(chan1_ctrl_q),
   .analog_input_four_taken_q(analog_input_four_taken_q));

/* verification/testbench.sv */
/* self-checking bench: reset values, update modes, control bits, readback.
 assumes the core model for bus cycles and the bound checker. */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dual_dac_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, v;
   logic sfr_wr, sfr_rd, sfr_hit_q, four, five;
   logic [8:0] r;
   chan_ctrl_s c0, c1;
   int fail_count = 0;
   int total_checks = 0;
   always #12.5 clk = ~clk;
   core_model core (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q));
   dual_dac_register_control uut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
      .sfr_hit_q(sfr_hit_q), .chan0_ctrl_q(c0), .chan1_ctrl_q(c1),
      .analog_input_four_taken_q(four), .analog_input_five_taken_q(five));
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [8:0] exp);
      core.rd(a, r);
      cmp({15'h0, r}, {15'h0, exp});
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #(25 * 3000);
      fail_count++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      // unmapped neighbours on both sides answer nothing
      for (int a = 8'hF8; a <= 8'hFE; a++)
         rdchk(a[7:0], a == 8'hFD ? 9'h104 : (a == 8'hF8 || a == 8'hFE) ? 9'h0 : 9'h100);
      $display("reset test done");
      core.wr(CONVERTER_CONTROL_ADDR, 8'h1F);
      core.wr(CHAN0_CODE_HIGH_ADDR, 8'h0A);
      settle();
      cmp({12'h0, c0.code}, 24'h000);
      core.wr(CHAN0_CODE_LOW_ADDR, 8'hBC);
      core.code(CHAN1_CODE_LOW_ADDR, 12'h567);
      core.wr(CHAN1_CODE_HIGH_ADDR, 8'hF5);
      settle();
      cmp({c1.code, c0.code}, 24'h567ABC);
      rdchk(CHAN1_CODE_HIGH_ADDR, 9'h1F5);
      for (int i = 0; i < 8; i++) begin
         v = 8'h04 | (8'h01 << i);
         core.wr(CONVERTER_CONTROL_ADDR, v);
         settle();
         cmp({c1.range_supply, c0.range_supply, c1.zero_force_n, c0.zero_force_n,
            c1.power_on, c0.power_on, five, four}, {16'h0, v[6:3], v[1:0], v[1:0]});
      end
      core.wr(CONVERTER_CONTROL_ADDR, 8'h9F);
      core.wr(CHAN0_CODE_LOW_ADDR, 8'h3C);
      settle();
      cmp({12'h0, c0.code}, 24'h3C0);
      core.wr(CONVERTER_CONTROL_ADDR, 8'h1B);
      core.code(CHAN0_CODE_LOW_ADDR, 12'h123);
      core.code(CHAN1_CODE_LOW_ADDR, 12'h456);
      settle();
      cmp({c1.code, c0.code}, 24'h5673C0);
      core.wr(CONVERTER_CONTROL_ADDR, 8'h1F);
      settle();
      cmp({c1.code, c0.code}, 24'h456123);
      rdchk(CONVERTER_CONTROL_ADDR, 9'h11F);
      $display("update test done");
      conclude();
   end
endmodule // testbench
